/* rtl/vat_pkg.sv */
// Purpose: Types shared by the address translation block
// Assumes: One-hot state codes
// Notes: Widths that depend on parameters stay local to the module
package vat_pkg;

  typedef enum logic [2:0] {
    SIDE_IDLE = 3'h1,
    SIDE_WAIT = 3'h2,
    SIDE_RESP = 3'h4
  } side_state_t;

  typedef enum logic [2:0] {
    SRCH_IDLE = 3'h1,
    SRCH_SCAN = 3'h2,
    SRCH_DONE = 3'h4
  } search_state_t;

endpackage

/* rtl/vat_regs.svh */
// Purpose: Register offsets, field positions and sizes of the address translation block
// Assumes: Registers sit at byte offsets inside an 8-bit decoded window
// Notes: Definitions only
`ifndef VAT_REGS_SVH
`define VAT_REGS_SVH

`define VAT_OFF_CTRL 8'h00
`define VAT_OFF_PID 8'h04
`define VAT_OFF_INDEX 8'h08
`define VAT_OFF_HI 8'h0C
`define VAT_OFF_LO 8'h10
`define VAT_OFF_RPN_EXT 8'h14
`define VAT_OFF_TAG_EXT 8'h18
`define VAT_OFF_ZONE 8'h1C
`define VAT_OFF_RPROT 8'h20
`define VAT_OFF_STATUS 8'h24

`define VAT_CTRL_VM 0
`define VAT_INDEX_TID_LSB 8
`define VAT_HI_TAG_LSB 10
`define VAT_HI_SIZE_LSB 7
`define VAT_HI_VALID 6
`define VAT_LO_RPN_LSB 10
`define VAT_LO_ZSEL_LSB 4
`define VAT_LO_EX 1
`define VAT_LO_WR 0

`define VAT_PAGE_BASE_BITS 10
`define VAT_UNIFIED_TRANSLATION_BUFFER_DEPTH 64
`define VAT_LANE_W 3
`define VAT_GROUP_W 3

`endif

/* rtl/virtual_address_translation.sv */
// Purpose: Effective to physical address translation with shadow and unified buffers
// Assumes: PA_W >= EA_W >= 32, shadow depths of at least 2, requesters on sys_clk
// Notes: AHB-Lite register slave with zero wait states; hreadyout is always high
`timescale 1ns/1ns
`include "vat_regs.svh"

module virtual_address_translation #(
  parameter int EA_W = 32,
  parameter int PA_W = 32,
  parameter int MMU_LEVEL = 3,
  parameter int AREA_OPT = 0,
  parameter int ISHADOW_DEPTH = 2,
  parameter int DSHADOW_DEPTH = 4
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Instruction fetch side
  input wire logic i_req,
  input wire logic [EA_W-1:0] i_ea,
  input wire logic i_user,
  output logic i_done,
  output logic [PA_W-1:0] i_pa,
  output logic i_miss,
  output logic i_fault,
  // Load/store side
  input wire logic d_req,
  input wire logic [EA_W-1:0] d_ea,
  input wire logic d_store,
  input wire logic d_user,
  output logic d_done,
  output logic [PA_W-1:0] d_pa,
  output logic d_miss,
  output logic d_fault,
  // Status
  output logic translating,
  output vat_pkg::search_state_t search_state
);
  import vat_pkg::*;

  localparam bit VIRT_HW = (MMU_LEVEL == 3) && (AREA_OPT == 0 || AREA_OPT == 2);
  localparam bit PROT_HW = (MMU_LEVEL > 1) && (AREA_OPT == 0 || AREA_OPT == 2);
  localparam int TW = EA_W - `VAT_PAGE_BASE_BITS;
  localparam int RW = PA_W - `VAT_PAGE_BASE_BITS;
  localparam int SH_MAX = (ISHADOW_DEPTH > DSHADOW_DEPTH) ? ISHADOW_DEPTH : DSHADOW_DEPTH;
  localparam int SPW = $clog2(SH_MAX);

  typedef struct packed {
    logic valid;
    logic [2:0] size;
    logic [7:0] entry_process_tag;
    logic [TW-1:0] tag;
    logic [RW-1:0] rpn;
    logic [3:0] zsel;
    logic ex;
    logic wr;
  } entry_t;

  typedef struct packed {
    side_state_t st;
    logic [EA_W-1:0] ea;
    logic user;
    logic store;
    logic [PA_W-1:0] pa;
    logic miss;
    logic fault;
  } side_t;

  typedef struct packed {
    logic vm;
    logic [7:0] process_identifier;
    logic [15:0] idx;
    logic [31:0] hi;
    logic [31:0] rpn_ext;
    logic [31:0] tag_ext;
    logic [31:0] zone;
    logic [31:0] rprot;
    logic [15:0] miss_cnt;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    entry_t [`VAT_UNIFIED_TRANSLATION_BUFFER_DEPTH-1:0] unified_translation_buffer;
    entry_t [1:0][SH_MAX-1:0] sh;
    logic [1:0][SPW-1:0] ptr;
    side_t [1:0] sd;
    search_state_t ss;
    logic sside;
    logic [`VAT_GROUP_W-1:0] grp;
    logic found_hit;
    entry_t found;
  } state_t;

  state_t s;
  state_t n;
  logic xlate;
  logic acc;
  logic commit;
  logic sh_hit;
  entry_t sh_e;
  entry_t new_e;
  entry_t lane_e;
  logic scan_hit;
  logic [1:0] rreq;
  logic [1:0] ruser;
  logic [1:0] rstore;
  logic [1:0][EA_W-1:0] rea;

  // Size field masks the compared page bits two at a time
  function automatic logic ent_hit(entry_t e, logic [EA_W-1:0] ea, logic [7:0] process_identifier);
    logic [TW-1:0] m;
    m = {TW{1'b1}} << {e.size, 1'b0};
    return e.valid && (((e.tag ^ ea[EA_W-1:`VAT_PAGE_BASE_BITS]) & m) == '0)
           && (e.entry_process_tag == 8'h00 || e.entry_process_tag == process_identifier);
  endfunction

  function automatic logic [PA_W-1:0] ent_pa(entry_t e, logic [EA_W-1:0] ea);
    logic [RW-1:0] m;
    logic [23:0] off;
    m = {RW{1'b1}} << {e.size, 1'b0};
    off = ea[23:0] & ((24'h000001 << (5'h0A + {1'b0, e.size, 1'b0})) - 24'h000001);
    return {e.rpn & m, 10'h000} | PA_W'(off);
  endfunction

  // Zone code: user 0 denies, 3 grants; supervisor codes 2 and 3 grant
  function automatic logic page_ok(entry_t e, logic user, logic exec, logic store, logic [31:0] zone);
    logic [1:0] z;
    logic ok;
    z = zone[{e.zsel, 1'b0} +: 2];
    ok = exec ? e.ex : (store ? e.wr : 1'b1);
    if (user) begin
      if (z == 2'h0) ok = 1'b0;
      else if (z == 2'h3) ok = 1'b1;
    end else if (z[1]) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  // Untranslated protection: 16 equal regions, low half store-deny, high half fetch-deny
  function automatic logic real_ok(logic [EA_W-1:0] ea, logic user, logic exec, logic store,
                                   logic [31:0] rprot);
    logic [3:0] r;
    r = ea[EA_W-1 -: 4];
    return !(user && (exec ? rprot[{1'b1, r}] : (store && rprot[{1'b0, r}])));
  endfunction

  assign rreq = {d_req, i_req};
  assign ruser = {d_user, i_user};
  assign rstore = {d_store, 1'b0};
  assign rea = {d_ea, i_ea};
  assign acc = hsel && hready && htrans[1];

  always_comb begin
    n = s;
    xlate = VIRT_HW && s.vm;
    commit = 1'b0;
    sh_hit = 1'b0;
    sh_e = '0;
    lane_e = '0;
    scan_hit = 1'b0;
    new_e.valid = s.hi[`VAT_HI_VALID];
    new_e.size = s.hi[`VAT_HI_SIZE_LSB +: 3];
    new_e.entry_process_tag = s.idx[`VAT_INDEX_TID_LSB +: 8];
    new_e.tag = TW'({s.tag_ext, s.hi[31:`VAT_HI_TAG_LSB]});
    new_e.rpn = RW'({s.rpn_ext, hwdata[31:`VAT_LO_RPN_LSB]});
    new_e.zsel = hwdata[`VAT_LO_ZSEL_LSB +: 4];
    new_e.ex = hwdata[`VAT_LO_EX];
    new_e.wr = hwdata[`VAT_LO_WR];
    // Data phase of a write
    if (s.wr_pend) begin
      case (s.wr_addr)
        `VAT_OFF_CTRL: n.vm = hwdata[`VAT_CTRL_VM];
        `VAT_OFF_PID: n.process_identifier = hwdata[7:0];
        `VAT_OFF_INDEX: n.idx = hwdata[15:0];
        `VAT_OFF_HI: n.hi = hwdata;
        `VAT_OFF_LO: commit = 1'b1;
        `VAT_OFF_RPN_EXT: n.rpn_ext = hwdata;
        `VAT_OFF_TAG_EXT: n.tag_ext = hwdata;
        `VAT_OFF_ZONE: n.zone = hwdata;
        `VAT_OFF_RPROT: n.rprot = hwdata;
        default: ;
      endcase
    end
    n.wr_pend = acc && hwrite;
    n.wr_addr = haddr[7:0];

    // Each side runs its own small machine on its own shadow buffer
    for (int k = 0; k < 2; k++) begin
      sh_hit = 1'b0;
      sh_e = '0;
      for (int j = 0; j < SH_MAX; j++) begin
        if (j < (k == 1 ? DSHADOW_DEPTH : ISHADOW_DEPTH) && !sh_hit
            && ent_hit(s.sh[k][j], rea[k], s.process_identifier)) begin
          sh_hit = 1'b1;
          sh_e = s.sh[k][j];
        end
      end
      unique case (s.sd[k].st)
        SIDE_IDLE: begin
          if (rreq[k]) begin
            n.sd[k].ea = rea[k];
            n.sd[k].user = ruser[k];
            n.sd[k].store = rstore[k];
            if (!xlate) begin
              n.sd[k].pa = PA_W'(rea[k]);
              n.sd[k].miss = 1'b0;
              n.sd[k].fault = PROT_HW && !real_ok(rea[k], ruser[k], k == 0, rstore[k], s.rprot);
              n.sd[k].st = SIDE_RESP;
            end else if (sh_hit) begin
              n.sd[k].pa = ent_pa(sh_e, rea[k]);
              n.sd[k].miss = 1'b0;
              n.sd[k].fault = !page_ok(sh_e, ruser[k], k == 0, rstore[k], s.zone);
              n.sd[k].st = SIDE_RESP;
            end else begin
              n.sd[k].st = SIDE_WAIT;
            end
          end
        end
        SIDE_WAIT: begin
          if (s.ss == SRCH_DONE && s.sside == k[0]) begin
            n.sd[k].pa = ent_pa(s.found, s.sd[k].ea);
            n.sd[k].miss = !s.found_hit;
            n.sd[k].fault = s.found_hit
                            && !page_ok(s.found, s.sd[k].user, k == 0, s.sd[k].store, s.zone);
            n.sd[k].st = SIDE_RESP;
            if (s.found_hit) begin
              // Round-robin refill, invisible to software
              n.sh[k][s.ptr[k]] = s.found;
              n.ptr[k] = (s.ptr[k] == SPW'((k == 1 ? DSHADOW_DEPTH : ISHADOW_DEPTH) - 1)) ? '0
                         : s.ptr[k] + 1'b1;
            end
          end
        end
        SIDE_RESP: n.sd[k].st = SIDE_IDLE;
        default: n.sd[k].st = SIDE_IDLE;
      endcase
    end

    // Unified buffer search, eight entries a cycle, so a search not queued behind the other side answers within 11 cycles
    unique case (s.ss)
      SRCH_IDLE: begin
        n.grp = '0;
        if (s.sd[1].st == SIDE_WAIT) begin
          n.sside = 1'b1;
          n.ss = SRCH_SCAN;
        end else if (s.sd[0].st == SIDE_WAIT) begin
          n.sside = 1'b0;
          n.ss = SRCH_SCAN;
        end
      end
      SRCH_SCAN: begin
        for (int l = 0; l < (1 << `VAT_LANE_W); l++) begin
          lane_e = s.unified_translation_buffer[{s.grp, `VAT_LANE_W'(l)}];
          if (!scan_hit && ent_hit(lane_e, s.sd[s.sside].ea, s.process_identifier)) begin
            scan_hit = 1'b1;
            n.found = lane_e;
          end
        end
        n.found_hit = scan_hit;
        if (scan_hit || s.grp == {`VAT_GROUP_W{1'b1}}) begin
          n.ss = SRCH_DONE;
          if (!scan_hit) n.miss_cnt = s.miss_cnt + 16'h0001;
        end else begin
          n.grp = s.grp + 1'b1;
        end
      end
      SRCH_DONE: n.ss = SRCH_IDLE;
      default: n.ss = SRCH_IDLE;
    endcase

    // Software writes are the only way an entry changes; shadows drop stale copies
    if (commit) begin
      n.unified_translation_buffer[s.idx[5:0]] = new_e;
      for (int k = 0; k < 2; k++) begin
        for (int j = 0; j < SH_MAX; j++) n.sh[k][j].valid = 1'b0;
      end
    end

    // Address phase of a read sees this cycle's write
    if (acc && !hwrite) begin
      case (haddr[7:0])
        `VAT_OFF_CTRL: n.rdata = {31'h00000000, n.vm};
        `VAT_OFF_PID: n.rdata = {24'h000000, n.process_identifier};
        `VAT_OFF_INDEX: n.rdata = {16'h0000, n.idx};
        `VAT_OFF_HI: n.rdata = n.hi;
        `VAT_OFF_LO: n.rdata = {n.unified_translation_buffer[n.idx[5:0]].rpn[21:0], 2'h0, n.unified_translation_buffer[n.idx[5:0]].zsel,
                                2'h0, n.unified_translation_buffer[n.idx[5:0]].ex, n.unified_translation_buffer[n.idx[5:0]].wr};
        `VAT_OFF_RPN_EXT: n.rdata = n.rpn_ext;
        `VAT_OFF_TAG_EXT: n.rdata = n.tag_ext;
        `VAT_OFF_ZONE: n.rdata = n.zone;
        `VAT_OFF_RPROT: n.rdata = n.rprot;
        `VAT_OFF_STATUS: n.rdata = {s.miss_cnt, 14'h0000, s.ss != SRCH_IDLE, xlate};
        default: n.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.sd[0].st <= SIDE_IDLE;
      s.sd[1].st <= SIDE_IDLE;
      s.ss <= SRCH_IDLE;
    end else if (clk_en) begin
      s <= n;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign i_done = s.sd[0].st == SIDE_RESP;
  assign i_pa = s.sd[0].pa;
  assign i_miss = s.sd[0].miss;
  assign i_fault = s.sd[0].fault;
  assign d_done = s.sd[1].st == SIDE_RESP;
  assign d_pa = s.sd[1].pa;
  assign d_miss = s.sd[1].miss;
  assign d_fault = s.sd[1].fault;
  assign translating = xlate;
  assign search_state = s.ss;

  a_real_pass_through: assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && !xlate && d_req && s.sd[1].st == SIDE_IDLE) |=> (d_done && d_pa == PA_W'($past(d_ea))))
    else $error("untranslated address altered");
  a_reset_untranslated: assert property (@(posedge sys_clk) disable iff (reset)
    $past(reset) |-> !translating)
    else $error("translation on after reset");
  a_vm_clear_mode: assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && s.wr_pend && s.wr_addr == `VAT_OFF_CTRL && !hwdata[0]) |=> !translating)
    else $error("clear of enable bit ignored");
  a_vm_set_mode: assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && s.wr_pend && s.wr_addr == `VAT_OFF_CTRL && hwdata[0]) |=> (translating == VIRT_HW))
    else $error("set of enable bit wrong");
  a_no_real_lookup: assert property (@(posedge sys_clk) disable iff (reset)
    (!xlate && s.sd[1].st == SIDE_IDLE) |=> (s.sd[1].st != SIDE_WAIT && !(d_done && d_miss)))
    else $error("lookup in untranslated mode");
  a_data_first_grant: assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && s.ss == SRCH_IDLE && s.sd[0].st == SIDE_WAIT && s.sd[1].st == SIDE_WAIT)
      |=> (s.ss == SRCH_SCAN && s.sside))
    else $error("instruction side won over data side");
  a_miss_latency_bound: assert property (@(posedge sys_clk) disable iff (reset || !clk_en)
    (s.sd[1].st == SIDE_IDLE && n.sd[1].st == SIDE_WAIT && s.sd[0].st != SIDE_WAIT) |-> ##[4:11] d_done)
    else $error("data miss not resolved in time");
  a_offset_kept: assert property (@(posedge sys_clk) disable iff (reset)
    (d_done && !d_miss) |-> (d_pa[9:0] == s.sd[1].ea[9:0]))
    else $error("page offset changed");
endmodule // virtual_address_translation

/* test/requester_model.sv */
// Purpose: Fetch and load/store requesters facing the translation block
// Assumes: One outstanding request per side, EA_W = PA_W = 32
// Notes: The bench drives it through its two tasks
`timescale 1ns/1ns
module requester_model (
  // Clock
  input wire logic sys_clk,
  // Fetch side
  output logic i_req,
  output logic [31:0] i_ea,
  output logic i_user,
  input wire logic i_done,
  input wire logic [31:0] i_pa,
  input wire logic i_miss,
  input wire logic i_fault,
  // Load/store side
  output logic d_req,
  output logic [31:0] d_ea,
  output logic d_store,
  output logic d_user,
  input wire logic d_done,
  input wire logic [31:0] d_pa,
  input wire logic d_miss,
  input wire logic d_fault
);
  initial begin
    i_req = 1'b0;
    i_ea = 32'h0;
    i_user = 1'b0;
    d_req = 1'b0;
    d_ea = 32'h0;
    d_store = 1'b0;
    d_user = 1'b0;
  end

  // Held until done is sampled; the address is then inverted so no one leans on a stale value
  task automatic fetch(input logic [31:0] ea, input logic usr, output logic [33:0] res, output int lat);
    lat = -1;
    @(posedge sys_clk);
    i_req <= 1'b1;
    i_ea <= ea;
    i_user <= usr;
    do begin
      @(posedge sys_clk);
      lat++;
    end while (i_done !== 1'b1 && lat < 100);
    res = {i_miss, i_fault, i_pa};
    i_req <= 1'b0;
    i_ea <= ~ea;
    i_user <= ~usr;
  endtask

  task automatic access(input logic [31:0] ea, input logic st, input logic usr, output logic [33:0] res,
                        output int lat);
    lat = -1;
    @(posedge sys_clk);
    d_req <= 1'b1;
    d_ea <= ea;
    d_store <= st;
    d_user <= usr;
    do begin
      @(posedge sys_clk);
      lat++;
    end while (d_done !== 1'b1 && lat < 100);
    res = {d_miss, d_fault, d_pa};
    d_req <= 1'b0;
    d_ea <= ~ea;
    d_store <= ~st;
    d_user <= ~usr;
  endtask
endmodule // requester_model

/* test/test_virtual_address_translation.sv */
// Purpose: Self-checking bench for the address translation block
// Assumes: Zero-wait bus slave, EA_W = PA_W = 32
// Notes: Real mode, page sizes, process tags, arbitration, zones
`timescale 1ns/1ns
`include "vat_regs.svh"
module test_virtual_address_translation;
  logic sys_clk, reset, hsel, hwrite, i_req, i_user, i_done, i_miss, i_fault;
  logic d_req, d_store, d_user, d_done, d_miss, d_fault, hreadyout, hresp, translating;
  logic [31:0] haddr, hwdata, hrdata, i_ea, i_pa, d_ea, d_pa, ea, pexp, rd, dummy;
  logic [33:0] r, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  vat_pkg::search_state_t search_state;
  int error_cnt, n_checks, cycles, lat, lat2;

  virtual_address_translation u_virtual_address_translation (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .i_req(i_req), .i_ea(i_ea),
    .i_user(i_user), .i_done(i_done), .i_pa(i_pa), .i_miss(i_miss), .i_fault(i_fault), .d_req(d_req),
    .d_ea(d_ea), .d_store(d_store), .d_user(d_user), .d_done(d_done), .d_pa(d_pa), .d_miss(d_miss),
    .d_fault(d_fault), .translating(translating), .search_state(search_state));
  requester_model u_requester_model (.sys_clk(sys_clk), .i_req(i_req), .i_ea(i_ea), .i_user(i_user),
    .i_done(i_done), .i_pa(i_pa), .i_miss(i_miss), .i_fault(i_fault), .d_req(d_req), .d_ea(d_ea),
    .d_store(d_store), .d_user(d_user), .d_done(d_done), .d_pa(d_pa), .d_miss(d_miss), .d_fault(d_fault));

  always #2 sys_clk = ~sys_clk;

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic s);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %b seen %b", nm, e, s);
    end
  endtask

  task automatic chk_rng(input string nm, input int s, input int lo, input int hi);
    n_checks++;
    if (s < lo || s > hi) begin
      error_cnt++;
      $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, s);
    end
  endtask

  // Address phase held until hready, then data phase held until hready again
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdo);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rdo = hrdata;
    chk1("hresp", 1'b0, hresp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, dummy);
  endtask

  // Entries get zone 0 with execute and write allowed
  task automatic put_entry(input logic [5:0] idx, input logic [7:0] entry_process_tag, input logic [31:0] va,
                           input logic [2:0] sz, input logic [31:0] rpn);
    wr(`VAT_OFF_INDEX, {16'h0, entry_process_tag, 2'h0, idx});
    wr(`VAT_OFF_HI, {va[31:10], sz, 1'b1, 6'h0});
    wr(`VAT_OFF_LO, {rpn[31:10], 10'h003});
  endtask

  // Physical address is only meaningful when neither miss nor fault is expected
  task automatic xd(input logic [31:0] va, input logic st, input logic usr, input logic [31:0] epa,
                    input logic emiss, input logic eflt);
    u_requester_model.access(va, st, usr, r, lat);
    chk_rng("data latency", lat, 1, 32);
    chk1("data miss", emiss, r[33]);
    chk1("data fault", eflt, r[32]);
    if (!emiss && !eflt) begin
      chk32("data pa", epa, r[31:0]);
    end
  endtask

  function automatic logic [31:0] msk(input int s);
    return (32'h1 << (10 + 2 * s)) - 32'h1;
  endfunction

  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    chk1("translating", 1'b0, translating);
    xd(32'h1234_5678, 1'b1, 1'b1, 32'h1234_5678, 1'b0, 1'b0);
    chk_rng("real latency", lat, 1, 1);
    u_requester_model.fetch(32'hC000_0100, 1'b1, r, lat);
    chk32("fetch pa", 32'hC000_0100, r[31:0]);
    wr(`VAT_OFF_RPROT, 32'h0008_0008);
    xd(32'h3000_0010, 1'b1, 1'b1, 32'h3000_0010, 1'b0, 1'b1);
    xd(32'h3000_0010, 1'b1, 1'b0, 32'h3000_0010, 1'b0, 1'b0);
    xd(32'h3000_0010, 1'b0, 1'b1, 32'h3000_0010, 1'b0, 1'b0);
    u_requester_model.fetch(32'h3000_0020, 1'b1, r, lat);
    chk1("fetch fault", 1'b1, r[32]);
    wr(`VAT_OFF_RPROT, 32'h0);
    wr(`VAT_OFF_PID, 32'h21);
    ahb(1'b0, `VAT_OFF_PID, 32'h0, rd);
    chk32("pid", 32'h21, rd);
    ahb(1'b0, 8'hF0, 32'h0, rd);
    chk32("unmapped", 32'h0, rd);
    wr(`VAT_OFF_ZONE, 32'hFFFF_FFFF);
    for (int s = 0; s < 8; s++) begin
      put_entry(6'(s), 8'h21, {8'h40 + 8'(s), 24'h9BCDE4}, 3'(s), {8'h80 + 8'(s), 24'hFFFFFF} & ~msk(s));
    end
    wr(`VAT_OFF_CTRL, 32'h1);
    @(posedge sys_clk);
    chk1("translating", 1'b1, translating);
    for (int s = 0; s < 8; s++) begin
      ea = {8'h40 + 8'(s), 24'h9BCDE4};
      pexp = ({8'h80 + 8'(s), 24'hFFFFFF} & ~msk(s)) | (ea & msk(s));
      xd(ea, 1'b0, 1'b0, pexp, 1'b0, 1'b0);
      chk_rng("miss latency", lat, 2, 32);
      xd(ea ^ 32'h204, 1'b0, 1'b0, pexp ^ 32'h204, 1'b0, 1'b0);
      chk_rng("hit latency", lat, 1, 1);
    end
    put_entry(6'd8, 8'h00, 32'h5000_0000, 3'd1, 32'h7700_0000);
    put_entry(6'd9, 8'h33, 32'h6000_0000, 3'd1, 32'h7800_0000);
    xd(32'h5000_0010, 1'b0, 1'b0, 32'h7700_0010, 1'b0, 1'b0);
    xd(32'h6000_0010, 1'b0, 1'b0, 32'h0, 1'b1, 1'b0);
    xd(32'h7000_0000, 1'b0, 1'b0, 32'h0, 1'b1, 1'b0);
    wr(`VAT_OFF_PID, 32'h33);
    xd(32'h6000_0010, 1'b0, 1'b0, 32'h7800_0010, 1'b0, 1'b0);
    xd(32'h5000_0010, 1'b0, 1'b0, 32'h7700_0010, 1'b0, 1'b0);
    // Commit empties both shadows, so both sides contend for the unified search
    put_entry(6'd10, 8'h00, 32'h9000_0000, 3'd7, 32'hA000_0000);
    fork
      u_requester_model.fetch(32'h9000_0040, 1'b0, r, lat);
      u_requester_model.access(32'h5000_0020, 1'b0, 1'b0, q, lat2);
      begin
        repeat (4) @(posedge sys_clk);
        chk32("search state", 32'(vat_pkg::SRCH_SCAN), 32'(search_state));
      end
    join
    chk32("fetch pa", 32'hA000_0040, r[31:0]);
    chk1("fetch miss", 1'b0, r[33]);
    chk_rng("fetch latency", lat, 2, 32);
    chk32("data pa", 32'h7700_0020, q[31:0]);
    chk_rng("data wait", lat2, 2, lat);
    wr(`VAT_OFF_ZONE, 32'h0);
    xd(32'h5000_0020, 1'b0, 1'b1, 32'h7700_0020, 1'b0, 1'b1);
    xd(32'h5000_0020, 1'b0, 1'b0, 32'h7700_0020, 1'b0, 1'b0);
    wr(`VAT_OFF_INDEX, 32'h0000_0008);
    ahb(1'b0, `VAT_OFF_LO, 32'h0, rd);
    chk32("entry 8", 32'h7700_0003, rd);
    wr(`VAT_OFF_CTRL, 32'h0);
    @(posedge sys_clk);
    chk1("translating", 1'b0, translating);
    xd(32'h5000_0020, 1'b0, 1'b0, 32'h5000_0020, 1'b0, 1'b0);
    ahb(1'b0, `VAT_OFF_STATUS, 32'h0, rd);
    chk32("status", 32'h0002_0000, rd);
    give_verdict();
  end
endmodule // test_virtual_address_translation
